/* rtl/rirq_status.sv */
// Purpose: general and receive event status with enables and interrupt pin
// Assumes: event inputs are one-cycle pulses synchronous to aclk
// Notes: registers reached over AXI4-Lite
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module rirq_status
	import rirq_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// radio core
	input wire rirq_gen_evt_s gen_evt,
	input wire rirq_rx_evt_s rx_evt,
	input wire rirq_radio_s radio,
	// interrupt pin
	output logic irq_n
);
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [9:0] waddr_reg, waddr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic wstrb_reg, wstrb_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] gen_stat_reg, gen_stat_next, rx_stat_reg, rx_stat_next;
	logic [7:0] gen_en_reg, gen_en_next, rx_en_reg, rx_en_next;
	logic [7:0] gen_defer_reg, gen_defer_next, rx_defer_reg, rx_defer_next;
	logic defer_reg, defer_next, wake_supp_reg, wake_supp_next;
	logic [5:0] fmt_reg, fmt_next;
	logic [5:0] txq_hi_reg, txq_hi_next, txq_lo_reg, txq_lo_next;
	logic [5:0] rxq_hi_reg, rxq_hi_next, rxq_lo_reg, rxq_lo_next;
	logic pde_reg, pde_next, tune_dis_reg, tune_dis_next;
	logic asleep_d_reg, fuse_boot_reg, full_c_reg, empty_c_reg;
	logic div_pend_reg, div_pend_next;
	rirq_rx_e rx_state_reg, rx_state_next;
	logic [7:0] rx_len_reg, rx_len_next, rx_cnt_reg, rx_cnt_next;
	logic irq_n_reg, irq_n_next;
	logic do_wr, do_rd, wr_ok, rd_ok, wr_gen, wr_rx, full_c, empty_c, wake_exit, len_bad;
	logic [7:0] gen_ev, rx_ev, gen_keep, rx_keep;
	logic [9:0] ridx;

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign irq_n = irq_n_reg;

	function automatic logic rirq_len_bad(input logic [7:0] len, input logic [5:0] fmt);
		logic r;
		logic [1:0] ext;
		logic [1:0] crc;
		r = 1'b0;
		ext = fmt[RIRQ_EXT_LSB +: 2];
		crc = fmt[RIRQ_CRC_LSB +: 2];
		case (fmt[RIRQ_FMT_LSB +: 2])
			RIRQ_FMT_A: begin
				case (ext)
					RIRQ_EXT_NONE: r = len < RIRQ_LEN_A_NONE;
					RIRQ_EXT_2B: r = len < RIRQ_LEN_A_2B;
					default: r = len < RIRQ_LEN_A_8B;
				endcase
			end
			RIRQ_FMT_B: begin
				r = len >= RIRQ_LEN_B_HOLE_LO && len <= RIRQ_LEN_B_HOLE_HI;
				if (ext == RIRQ_EXT_8B) begin
					r = r || len < RIRQ_LEN_B8_MIN || (len >= RIRQ_LEN_B8_GAP_LO && len <= RIRQ_LEN_B8_GAP_HI);
				end else begin
					r = r || len < RIRQ_LEN_B_MIN;
				end
			end
			RIRQ_FMT_C: r = (crc >= RIRQ_LEN_C32[1:0]) ? (len == RIRQ_LEN_C32) : (len == {6'h00, crc});
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// bus slave
	always_comb begin
		do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
		do_rd = s_axi_arvalid && arready_reg;
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		if (s_axi_awvalid && awready_reg) begin
			aw_full_next = 1'b1;
			waddr_next = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && wready_reg) begin
			w_full_next = 1'b1;
			wdata_next = s_axi_wdata[7:0];
			wstrb_next = s_axi_wstrb[0];
		end
		if (do_wr) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
		end
		bvalid_next = bvalid_reg ? !s_axi_bready : do_wr;
		wr_ok = 1'b1;
		case (waddr_reg)
			RIRQ_IDX_PKT_FMT, RIRQ_IDX_GEN_STAT, RIRQ_IDX_RX_STAT, RIRQ_IDX_GEN_EN,
			RIRQ_IDX_RX_EN, RIRQ_IDX_TXQ_HI, RIRQ_IDX_TXQ_LO, RIRQ_IDX_RXQ_HI,
			RIRQ_IDX_RXQ_LO, RIRQ_IDX_SLEEP_SET, RIRQ_IDX_TUNE: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
		bresp_next = do_wr ? (wr_ok ? RIRQ_RESP_OKAY : RIRQ_RESP_SLVERR) : bresp_reg;
		awready_next = !aw_full_next && !bvalid_next;
		wready_next = !w_full_next && !bvalid_next;
		ridx = s_axi_araddr[11:2];
		rd_ok = 1'b1;
		rdata_next = rdata_reg;
		if (do_rd) begin
			rdata_next = 32'h0000_0000;
			case (ridx)
				RIRQ_IDX_PKT_FMT: rdata_next[5:0] = fmt_reg;
				RIRQ_IDX_GEN_STAT: rdata_next[7:0] = gen_stat_reg;
				RIRQ_IDX_RX_STAT: rdata_next[7:0] = rx_stat_reg;
				RIRQ_IDX_GEN_EN: rdata_next[7:0] = gen_en_reg;
				RIRQ_IDX_RX_EN: rdata_next[7:0] = rx_en_reg;
				RIRQ_IDX_TXQ_HI: rdata_next[5:0] = txq_hi_reg;
				RIRQ_IDX_TXQ_LO: rdata_next[5:0] = txq_lo_reg;
				RIRQ_IDX_RXQ_HI: rdata_next[5:0] = rxq_hi_reg;
				RIRQ_IDX_RXQ_LO: rdata_next[5:0] = rxq_lo_reg;
				RIRQ_IDX_SLEEP_SET: rdata_next[RIRQ_PDE_BIT] = pde_reg;
				RIRQ_IDX_TUNE: rdata_next[RIRQ_TUNE_DIS_BIT] = tune_dis_reg;
				default: rd_ok = 1'b0;
			endcase
		end
		rresp_next = do_rd ? (rd_ok ? RIRQ_RESP_OKAY : RIRQ_RESP_SLVERR) : rresp_reg;
		rvalid_next = rvalid_reg ? !s_axi_rready : do_rd;
		arready_next = !rvalid_next;
	end

	// configuration registers
	always_comb begin
		wr_gen = do_wr && wstrb_reg && waddr_reg == RIRQ_IDX_GEN_STAT;
		wr_rx = do_wr && wstrb_reg && waddr_reg == RIRQ_IDX_RX_STAT;
		gen_en_next = gen_en_reg;
		rx_en_next = rx_en_reg;
		fmt_next = fmt_reg;
		txq_hi_next = txq_hi_reg;
		txq_lo_next = txq_lo_reg;
		rxq_hi_next = rxq_hi_reg;
		rxq_lo_next = rxq_lo_reg;
		pde_next = pde_reg;
		tune_dis_next = tune_dis_reg;
		if (do_wr && wstrb_reg) begin
			case (waddr_reg)
				RIRQ_IDX_GEN_EN: gen_en_next = wdata_reg;
				RIRQ_IDX_RX_EN: rx_en_next = wdata_reg;
				RIRQ_IDX_PKT_FMT: fmt_next = wdata_reg[5:0];
				RIRQ_IDX_TXQ_HI: txq_hi_next = wdata_reg[5:0];
				RIRQ_IDX_TXQ_LO: txq_lo_next = wdata_reg[5:0];
				RIRQ_IDX_RXQ_HI: rxq_hi_next = wdata_reg[5:0];
				RIRQ_IDX_RXQ_LO: rxq_lo_next = wdata_reg[5:0];
				RIRQ_IDX_SLEEP_SET: pde_next = wdata_reg[RIRQ_PDE_BIT];
				RIRQ_IDX_TUNE: tune_dis_next = wdata_reg[RIRQ_TUNE_DIS_BIT];
				default: ;
			endcase
		end
	end

	// receive packet tracker
	always_comb begin
		rx_state_next = rx_state_reg;
		rx_len_next = rx_len_reg;
		rx_cnt_next = rx_cnt_reg;
		div_pend_next = div_pend_reg;
		rx_ev = 8'h00;
		len_bad = rirq_len_bad(rx_evt.len_field, fmt_reg);
		if (rx_evt.sync_detect && div_pend_reg) begin
			rx_ev[RIRQ_R_DIV] = 1'b1;
			div_pend_next = 1'b0;
		end
		// a search ending at a sync stays pending for the next sync
		if (rx_evt.div_search_done) begin
			div_pend_next = 1'b1;
		end
		rx_ev[RIRQ_R_FIELD] = rx_evt.field_check;
		rx_ev[RIRQ_R_SYNC] = rx_evt.sync_detect;
		rx_ev[RIRQ_R_CRC] = rx_evt.crc_fail;
		rx_ev[RIRQ_R_FIFOERR] = radio.rx_active && radio.fifo_mode &&
			(rx_evt.fifo_overrun || rx_evt.fifo_underrun);
		case (rx_state_reg)
			RIRQ_RX_IDLE: begin
				if (rx_evt.sync_detect) begin
					rx_state_next = RIRQ_RX_SYNC;
				end
			end
			RIRQ_RX_SYNC: begin
				if (rx_evt.sync_lost) begin
					rx_ev[RIRQ_R_SYNCERR] = 1'b1;
					rx_state_next = RIRQ_RX_IDLE;
				end else if (rx_evt.len_valid) begin
					rx_ev[RIRQ_R_LENERR] = len_bad;
					rx_len_next = rx_evt.len_field;
					rx_cnt_next = 8'h00;
					rx_state_next = len_bad ? RIRQ_RX_IDLE : RIRQ_RX_DATA;
				end
			end
			RIRQ_RX_DATA: begin
				if (rx_evt.sync_lost) begin
					rx_ev[RIRQ_R_SYNCERR] = 1'b1;
					rx_state_next = RIRQ_RX_IDLE;
				end else if (rx_evt.byte_rx) begin
					rx_cnt_next = rx_cnt_reg + 8'h01;
					if (rx_cnt_next == rx_len_reg) begin
						rx_ev[RIRQ_R_DONE] = 1'b1;
						rx_state_next = RIRQ_RX_IDLE;
					end
				end
			end
			default: rx_state_next = RIRQ_RX_IDLE;
		endcase
	end

	// status, deferred clears and pin
	always_comb begin
		full_c = (radio.tx_active && radio.fifo_level > {1'b0, txq_hi_reg}) ||
			(radio.rx_active && radio.fifo_level > {1'b0, rxq_hi_reg});
		empty_c = (radio.tx_active && radio.fifo_level < {1'b0, txq_lo_reg}) ||
			(radio.rx_active && radio.fifo_level < {1'b0, rxq_lo_reg});
		wake_exit = asleep_d_reg && !radio.asleep;
		wake_supp_next = wake_supp_reg;
		if (wr_gen && radio.asleep && !wdata_reg[RIRQ_G_WAKE]) begin
			wake_supp_next = 1'b1;
		end
		if (wake_exit) begin
			wake_supp_next = 1'b0;
		end
		gen_ev = 8'h00;
		gen_ev[RIRQ_G_CLKCAL] = gen_evt.clk_cal_done;
		gen_ev[RIRQ_G_WAKE] = gen_evt.wake_timer_done && !wake_supp_reg;
		gen_ev[RIRQ_G_FULL] = full_c && !full_c_reg;
		gen_ev[RIRQ_G_EMPTY] = empty_c && !empty_c_reg;
		gen_ev[RIRQ_G_RFSTATE] = gen_evt.rf_state_done;
		gen_ev[RIRQ_G_UNLOCK] = gen_evt.pll_unlock || (gen_evt.tune_out_of_range && !tune_dis_reg);
		gen_ev[RIRQ_G_CALFUSE] = gen_evt.vco_cal_done || gen_evt.iq_adj_done || fuse_boot_reg ||
			(wake_exit && pde_reg);
		gen_ev[RIRQ_G_CLKSTB] = gen_evt.clk_stable_done;
		gen_keep = 8'hff;
		rx_keep = 8'hff;
		gen_defer_next = gen_defer_reg;
		rx_defer_next = rx_defer_reg;
		defer_next = defer_reg;
		if (radio.asleep) begin
			if (wr_gen) begin
				gen_defer_next = gen_defer_reg & wdata_reg;
				defer_next = 1'b1;
			end
			if (wr_rx) begin
				rx_defer_next = rx_defer_reg & wdata_reg;
				defer_next = 1'b1;
			end
		end else begin
			if (wr_gen) begin
				gen_keep = wdata_reg;
			end
			if (wr_rx) begin
				rx_keep = wdata_reg;
			end
			if (defer_reg && gen_evt.clk_stable_done) begin
				gen_keep = gen_keep & gen_defer_reg;
				rx_keep = rx_keep & rx_defer_reg;
				gen_defer_next = 8'hff;
				rx_defer_next = 8'hff;
				defer_next = 1'b0;
			end
		end
		// set wins over clear; enables never gate capture
		gen_stat_next = (gen_stat_reg & gen_keep) | gen_ev;
		rx_stat_next = (rx_stat_reg & rx_keep) | rx_ev;
		irq_n_next = !(|(gen_stat_next & gen_en_next) || |(rx_stat_next & rx_en_next));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RIRQ_RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= RIRQ_RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			waddr_reg <= 10'h000;
			wdata_reg <= 8'h00;
			wstrb_reg <= 1'b0;
			gen_stat_reg <= RIRQ_STAT_RST;
			rx_stat_reg <= RIRQ_STAT_RST;
			gen_en_reg <= RIRQ_EN_RST;
			rx_en_reg <= RIRQ_EN_RST;
			gen_defer_reg <= 8'hff;
			rx_defer_reg <= 8'hff;
			defer_reg <= 1'b0;
			wake_supp_reg <= 1'b0;
			fmt_reg <= RIRQ_FMT_RST;
			txq_hi_reg <= RIRQ_LVL_RST;
			txq_lo_reg <= RIRQ_LVL_RST;
			rxq_hi_reg <= RIRQ_LVL_RST;
			rxq_lo_reg <= RIRQ_LVL_RST;
			pde_reg <= 1'b0;
			tune_dis_reg <= 1'b0;
			asleep_d_reg <= 1'b0;
			fuse_boot_reg <= 1'b1;
			full_c_reg <= 1'b0;
			empty_c_reg <= 1'b0;
			div_pend_reg <= 1'b0;
			rx_state_reg <= RIRQ_RX_IDLE;
			rx_len_reg <= 8'h00;
			rx_cnt_reg <= 8'h00;
			irq_n_reg <= 1'b1;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			gen_stat_reg <= gen_stat_next;
			rx_stat_reg <= rx_stat_next;
			gen_en_reg <= gen_en_next;
			rx_en_reg <= rx_en_next;
			gen_defer_reg <= gen_defer_next;
			rx_defer_reg <= rx_defer_next;
			defer_reg <= defer_next;
			wake_supp_reg <= wake_supp_next;
			fmt_reg <= fmt_next;
			txq_hi_reg <= txq_hi_next;
			txq_lo_reg <= txq_lo_next;
			rxq_hi_reg <= rxq_hi_next;
			rxq_lo_reg <= rxq_lo_next;
			pde_reg <= pde_next;
			tune_dis_reg <= tune_dis_next;
			asleep_d_reg <= radio.asleep;
			fuse_boot_reg <= 1'b0;
			full_c_reg <= full_c;
			empty_c_reg <= empty_c;
			div_pend_reg <= div_pend_next;
			rx_state_reg <= rx_state_next;
			rx_len_reg <= rx_len_next;
			rx_cnt_reg <= rx_cnt_next;
			irq_n_reg <= irq_n_next;
		end
	end

	default clocking rirq_cb @(posedge aclk); endclocking
	// first edge after release still samples reset-time state
	default disable iff (!aresetn || fuse_boot_reg);

	irq_pin_level_a: assert property (
		irq_n_reg == !(|(gen_stat_reg & gen_en_reg) || |(rx_stat_reg & rx_en_reg)))
		else $error("interrupt pin disagrees with enabled status");
	mask_no_gate_a: assert property ((|gen_ev) |=>
		((gen_stat_reg & $past(gen_ev)) == $past(gen_ev))) else $error("event lost in general status");
	gen_clear_a: assert property (wr_gen && !radio.asleep && !defer_reg |=>
		gen_stat_reg == (($past(gen_stat_reg) & $past(wdata_reg)) | $past(gen_ev)))
		else $error("general status write did not clear zeros only");
	rx_clear_a: assert property (wr_rx && !radio.asleep && !defer_reg |=>
		rx_stat_reg == (($past(rx_stat_reg) & $past(wdata_reg)) | $past(rx_ev)))
		else $error("receive status write did not clear zeros only");
	sleep_defer_a: assert property (wr_gen && radio.asleep |=>
		gen_stat_reg == ($past(gen_stat_reg) | $past(gen_ev))) else $error("status cleared during sleep");
	wake_supp_a: assert property (wake_supp_reg |-> !gen_ev[RIRQ_G_WAKE])
		else $error("wake event raised after sleep clear");
	fuse_wake_a: assert property ($fell(radio.asleep) && pde_reg |=> gen_stat_reg[RIRQ_G_CALFUSE])
		else $error("fuse done missing after wake");
	fifo_full_a: assert property (full_c && !full_c_reg |=> gen_stat_reg[RIRQ_G_FULL])
		else $error("fifo full event missing");
	tune_unlock_a: assert property (gen_evt.tune_out_of_range && !tune_dis_reg |=> gen_stat_reg[RIRQ_G_UNLOCK])
		else $error("tuning range event missing");
	rx_done_a: assert property (rx_state_reg == RIRQ_RX_DATA && rx_evt.byte_rx && !rx_evt.sync_lost &&
		rx_cnt_reg + 8'h01 == rx_len_reg |=> rx_stat_reg[RIRQ_R_DONE] && rx_state_reg == RIRQ_RX_IDLE)
		else $error("receive done missing");
	div_sync_a: assert property (div_pend_reg && rx_evt.sync_detect |=> rx_stat_reg[RIRQ_R_DIV])
		else $error("diversity done not raised at sync");
	write_resp_a: assert property (do_wr |=> s_axi_bvalid)
		else $error("write response late");
	rx_done_c: cover property (rx_ev[RIRQ_R_DONE]);
	deferred_clear_c: cover property (defer_reg && gen_evt.clk_stable_done && !radio.asleep);
	len_err_c: cover property (rx_ev[RIRQ_R_LENERR]);
endmodule // rirq_status

/* rtl/rirq_pkg.sv */
// Purpose: constants and types for the radio event status and interrupt block
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit registers in the low byte
// Notes: byte address of a register is four times its index
package rirq_pkg;
	localparam logic [9:0] RIRQ_IDX_PKT_FMT = 10'h004;
	localparam logic [9:0] RIRQ_IDX_GEN_STAT = 10'h00d;
	localparam logic [9:0] RIRQ_IDX_RX_STAT = 10'h00e;
	localparam logic [9:0] RIRQ_IDX_GEN_EN = 10'h010;
	localparam logic [9:0] RIRQ_IDX_RX_EN = 10'h011;
	localparam logic [9:0] RIRQ_IDX_TXQ_HI = 10'h017;
	localparam logic [9:0] RIRQ_IDX_TXQ_LO = 10'h018;
	localparam logic [9:0] RIRQ_IDX_RXQ_HI = 10'h019;
	localparam logic [9:0] RIRQ_IDX_RXQ_LO = 10'h01a;
	localparam logic [9:0] RIRQ_IDX_SLEEP_SET = 10'h02d;
	localparam logic [9:0] RIRQ_IDX_TUNE = 10'h040;
	localparam logic [7:0] RIRQ_STAT_RST = 8'h00;
	localparam logic [7:0] RIRQ_EN_RST = 8'h00;
	localparam logic [5:0] RIRQ_LVL_RST = 6'h00;
	localparam logic [5:0] RIRQ_FMT_RST = 6'h00;
	// general status bit positions
	localparam int RIRQ_G_CLKCAL = 7;
	localparam int RIRQ_G_WAKE = 6;
	localparam int RIRQ_G_FULL = 5;
	localparam int RIRQ_G_EMPTY = 4;
	localparam int RIRQ_G_RFSTATE = 3;
	localparam int RIRQ_G_UNLOCK = 2;
	localparam int RIRQ_G_CALFUSE = 1;
	localparam int RIRQ_G_CLKSTB = 0;
	// receive status bit positions
	localparam int RIRQ_R_SYNCERR = 7;
	localparam int RIRQ_R_FIELD = 6;
	localparam int RIRQ_R_SYNC = 5;
	localparam int RIRQ_R_FIFOERR = 4;
	localparam int RIRQ_R_LENERR = 3;
	localparam int RIRQ_R_DIV = 2;
	localparam int RIRQ_R_CRC = 1;
	localparam int RIRQ_R_DONE = 0;
	// packet_format_control fields
	localparam int RIRQ_FMT_LSB = 0;
	localparam int RIRQ_EXT_LSB = 2;
	localparam int RIRQ_CRC_LSB = 4;
	localparam logic [1:0] RIRQ_FMT_A = 2'h0;
	localparam logic [1:0] RIRQ_FMT_B = 2'h1;
	localparam logic [1:0] RIRQ_FMT_C = 2'h2;
	localparam logic [1:0] RIRQ_EXT_NONE = 2'h0;
	localparam logic [1:0] RIRQ_EXT_2B = 2'h1;
	localparam logic [1:0] RIRQ_EXT_8B = 2'h2;
	localparam int RIRQ_PDE_BIT = 2;
	localparam int RIRQ_TUNE_DIS_BIT = 2;
	// length error limits
	localparam logic [7:0] RIRQ_LEN_A_NONE = 8'h08;
	localparam logic [7:0] RIRQ_LEN_A_2B = 8'h0c;
	localparam logic [7:0] RIRQ_LEN_A_8B = 8'h10;
	localparam logic [7:0] RIRQ_LEN_B_MIN = 8'h0a;
	localparam logic [7:0] RIRQ_LEN_B8_MIN = 8'h11;
	localparam logic [7:0] RIRQ_LEN_B8_GAP_LO = 8'h13;
	localparam logic [7:0] RIRQ_LEN_B8_GAP_HI = 8'h14;
	localparam logic [7:0] RIRQ_LEN_B_HOLE_LO = 8'h80;
	localparam logic [7:0] RIRQ_LEN_B_HOLE_HI = 8'h81;
	localparam logic [7:0] RIRQ_LEN_C32 = 8'h02;
	localparam logic [1:0] RIRQ_RESP_OKAY = 2'h0;
	localparam logic [1:0] RIRQ_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic clk_cal_done;
		logic wake_timer_done;
		logic rf_state_done;
		logic pll_unlock;
		logic tune_out_of_range;
		logic vco_cal_done;
		logic iq_adj_done;
		logic clk_stable_done;
	} rirq_gen_evt_s;

	typedef struct packed {
		logic sync_detect;
		logic sync_lost;
		logic field_check;
		logic fifo_overrun;
		logic fifo_underrun;
		logic div_search_done;
		logic crc_fail;
		logic len_valid;
		logic [7:0] len_field;
		logic byte_rx;
	} rirq_rx_evt_s;

	typedef struct packed {
		logic asleep;
		logic tx_active;
		logic rx_active;
		logic fifo_mode;
		logic [6:0] fifo_level;
	} rirq_radio_s;

	typedef enum logic [1:0] {
		RIRQ_RX_IDLE = 2'b00,
		RIRQ_RX_SYNC = 2'b01,
		RIRQ_RX_DATA = 2'b11
	} rirq_rx_e;
endpackage

/* bench/rirq_radio_model.sv */
// Purpose: radio core stand-in that drives event pulses
// Assumes: the bench commands one event burst at a time
// Notes: rx burst gives sync detect, then a length field, then one byte pulse per counted byte
`timescale 1ns/1ps
module rirq_radio_model
	import rirq_pkg::*;
(
	// clock
	input wire logic aclk,
	// commands from the bench
	input wire logic go,
	input wire logic rx_go,
	input wire logic sleep,
	input wire logic txa,
	input wire logic [7:0] pat,
	// radio core side
	output rirq_gen_evt_s gen_evt = '0,
	output rirq_rx_evt_s rx_evt = '0,
	output rirq_radio_s radio
);
	logic len_step = 1'b0;
	logic [7:0] nbytes = 8'h00;
	always @(posedge aclk) begin
		gen_evt <= go ? rirq_gen_evt_s'(pat) : '0;
		// length lines toggle when not qualified; the diversity search ends with the length field
		rx_evt <= '{sync_detect: rx_go, sync_lost: 1'b0, field_check: 1'b0, fifo_overrun: 1'b0,
			fifo_underrun: 1'b0, div_search_done: len_step, crc_fail: 1'b0, len_valid: len_step,
			len_field: len_step ? pat : ~pat, byte_rx: !len_step && nbytes != 8'h00};
		nbytes <= len_step ? pat : nbytes - {7'h00, nbytes != 8'h00};
		len_step <= rx_go;
	end
	assign radio = '{asleep: sleep, tx_active: txa, rx_active: 1'b0, fifo_mode: 1'b0, fifo_level: pat[6:0]};
endmodule // rirq_radio_model

/* bench/radio_irq_status_groups_tb_top.sv */
// Purpose: self-checking bench for the event status block
// Assumes: axi4-lite master tasks, radio model as event source
// Notes: reads queue expected values; a monitor compares them
`timescale 1ns/1ps
module radio_irq_status_groups_tb_top
	import rirq_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = '0;
	logic [11:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [7:0] pat = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic go = 1'b0, rx_go = 1'b0, sleep = 1'b0, txa = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq_n;
	logic [1:0] rresp, bresp;
	logic [31:0] rdata;
	rirq_gen_evt_s gen_evt;
	rirq_rx_evt_s rx_evt;
	rirq_radio_s radio;
	logic [33:0] expq[$];
	int errors = 0;
	int n_checks = 0;
	logic [31:0] seed = 32'h8957;
	logic [7:0] fm [7] = '{8'h00, 8'h00, 8'h09, 8'h09, 8'h01, 8'h22, 8'h02};
	logic [7:0] ln [7] = '{8'h07, 8'h08, 8'h13, 8'h15, 8'h80, 8'h02, 8'h01};
	logic [6:0] er = 7'b0110101;
	always #10 aclk = ~aclk;
	rirq_status rirq_status_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gen_evt(gen_evt),
		.rx_evt(rx_evt), .radio(radio), .irq_n(irq_n));
	rirq_radio_model rirq_radio_model_i (.aclk(aclk), .go(go), .rx_go(rx_go), .sleep(sleep), .txa(txa), .pat(pat),
		.gen_evt(gen_evt), .rx_evt(rx_evt), .radio(radio));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// event pulse pattern to general status bits
	function automatic logic [7:0] gmap(input logic [7:0] p);
		return {p[7], p[6], 2'b00, p[5], p[4] | p[3], p[2] | p[1], p[0]};
	endfunction
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] idx, input logic [33:0] exp);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		expq.push_back(exp);
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	task automatic ev(input logic [7:0] p, input logic r);
		@(posedge aclk);
		pat <= p;
		go <= !r;
		rx_go <= r;
		@(posedge aclk);
		go <= 1'b0;
		rx_go <= 1'b0;
		// rx bursts wait out the byte pulses, except the 128 pulses of the 0x80 length-error burst
		repeat (r ? 28 : 4) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1) chk({rresp, rdata}, expq.pop_front());
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(RIRQ_IDX_GEN_STAT, {RIRQ_RESP_OKAY, 32'h02});
		rd(RIRQ_IDX_RX_STAT, {RIRQ_RESP_OKAY, 32'h00});
		rd(RIRQ_IDX_RX_EN, {RIRQ_RESP_OKAY, 32'h00});
		rd(10'h3ff, {RIRQ_RESP_SLVERR, 32'h00});
		wr(10'h3ff, 8'h00);
		chk({32'h0, bresp}, {32'h0, RIRQ_RESP_SLVERR});
		wr(RIRQ_IDX_GEN_STAT, 8'hfd);
		chk({32'h0, bresp}, {32'h0, RIRQ_RESP_OKAY});
		rd(RIRQ_IDX_GEN_STAT, {RIRQ_RESP_OKAY, 32'h00});
		$display("test reset and clear done");
		ev(8'h20, 1'b0);
		rd(RIRQ_IDX_GEN_STAT, {RIRQ_RESP_OKAY, 32'h08});
		chk({33'h0, irq_n}, 34'h1);
		wr(RIRQ_IDX_GEN_EN, 8'h08);
		repeat (2) @(posedge aclk);
		chk({33'h0, irq_n}, 34'h0);
		wr(RIRQ_IDX_SLEEP_SET, 8'h04);
		sleep <= 1'b1;
		wr(RIRQ_IDX_GEN_STAT, 8'h00);
		rd(RIRQ_IDX_GEN_STAT, {RIRQ_RESP_OKAY, 32'h08});
		sleep <= 1'b0;
		rd(RIRQ_IDX_GEN_STAT, {RIRQ_RESP_OKAY, 32'h0a});
		ev(8'h01, 1'b0);
		rd(RIRQ_IDX_GEN_STAT, {RIRQ_RESP_OKAY, 32'h01});
		chk({33'h0, irq_n}, 34'h1);
		$display("test mask and sleep done");
		wr(RIRQ_IDX_TXQ_HI, 8'h10);
		wr(RIRQ_IDX_TXQ_LO, 8'h08);
		wr(RIRQ_IDX_GEN_STAT, 8'h00);
		pat <= 8'h30;
		txa <= 1'b1;
		rd(RIRQ_IDX_GEN_STAT, {RIRQ_RESP_OKAY, 32'h20});
		wr(RIRQ_IDX_GEN_STAT, 8'h00);
		pat <= 8'h02;
		rd(RIRQ_IDX_GEN_STAT, {RIRQ_RESP_OKAY, 32'h10});
		txa <= 1'b0;
		$display("test fifo levels done");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr(RIRQ_IDX_GEN_STAT, 8'h00);
			ev(seed[7:0], 1'b0);
			rd(RIRQ_IDX_GEN_STAT, {RIRQ_RESP_OKAY, 24'h0, gmap(seed[7:0])});
		end
		$display("test random events done");
		for (int i = 0; i < 7; i++) begin
			wr(RIRQ_IDX_PKT_FMT, fm[i]);
			wr(RIRQ_IDX_RX_STAT, 8'h00);
			ev(ln[i], 1'b1);
			rd(RIRQ_IDX_RX_STAT, {RIRQ_RESP_OKAY, 24'h0,
				(er[i] ? 8'h28 : 8'h21) | (i > 0 ? 8'h04 : 8'h00)});
		end
		$display("test length fields done");
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		report_and_stop();
	end
endmodule // radio_irq_status_groups_tb_top
